/* File: design/psc_defines.vh */
// constants for the two-channel pwm block: indices, fields, resets
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// register indices; the byte address is four times the index
`define PSC_IDX_CONTROL 9'h060
`define PSC_IDX_PRESCALE 9'h061
`define PSC_IDX_SCALE_A 9'h062
`define PSC_IDX_SCALE_B 9'h063
`define PSC_IDX_COUNTER0 9'h064
`define PSC_IDX_COUNTER1 9'h065
`define PSC_IDX_PERIOD0 9'h066
`define PSC_IDX_PERIOD1 9'h067
`define PSC_IDX_DUTY0 9'h068
`define PSC_IDX_DUTY1 9'h069

// control register fields
`define PSC_CTL_ENABLE_LSB 0
`define PSC_CTL_POLARITY_LSB 2
`define PSC_CTL_CLKCHOICE_LSB 4
`define PSC_CTL_CENTER_LSB 6

// prescale register fields
`define PSC_PRE_A_LSB 0
`define PSC_PRE_B_LSB 4
`define PSC_PRE_MASK 8'h77

// reset values
`define PSC_RST_BYTE 8'h00
`define PSC_RST_PRESC 7'h00

// scale counter reload point
`define PSC_SCALE_END 8'h01

`endif

/* File: design/psc_channel.v */
// one pwm channel: counter, double-buffered period and duty, output
`timescale 1ns/10ps
`default_nettype none
`include "psc_defines.vh"

module psc_channel (
  input wire clock,
  input wire sys_rst,
  input wire tick,
  input wire enable,
  input wire polarity,
  input wire center,
  input wire cntWrite,
  input wire perWrite,
  input wire dutyWrite,
  input wire [7:0] wdata,
  output wire [7:0] count,
  output wire [7:0] periodBuf,
  output wire [7:0] dutyBuf,
  output wire pwmOut
);

  reg [7:0] cnt_ff;
  reg [7:0] perBuf_ff;
  reg [7:0] dutyBuf_ff;
  reg [7:0] perAct_ff;
  reg [7:0] dutyAct_ff;
  reg down_ff;
  reg run_ff;
  reg out_ff;
  reg [7:0] nxt_cnt;
  reg [7:0] nxt_perBuf;
  reg [7:0] nxt_dutyBuf;
  reg [7:0] nxt_perAct;
  reg [7:0] nxt_dutyAct;
  reg nxt_down;
  reg nxt_run;
  reg nxt_out;
  reg periodEnd;
  reg load;
  wire [7:0] cntUp;
  wire [7:0] cntDown;

  assign cntUp = cnt_ff + 8'h01;
  assign cntDown = cnt_ff - 8'h01;

  // ==========================================================
  // next state
  always @*
  begin
    nxt_perBuf = perWrite ? wdata : perBuf_ff;
    nxt_dutyBuf = dutyWrite ? wdata : dutyBuf_ff;
    nxt_cnt = cnt_ff;
    nxt_down = down_ff;
    periodEnd = 1'b0;
    // enable only takes hold on an edge of the channel clock
    nxt_run = tick ? enable : run_ff;
    if (!enable)
      nxt_run = 1'b0;
    if (run_ff && enable && tick)
    begin
      if (!center)
      begin
        if (cntUp >= perAct_ff)
        begin
          nxt_cnt = 8'h00;
          periodEnd = 1'b1;
        end
        else
          nxt_cnt = cntUp;
      end
      else if (!down_ff)
      begin
        nxt_cnt = cntUp;
        if (cntUp >= perAct_ff)
          nxt_down = 1'b1;
      end
      else
      begin
        nxt_cnt = cntDown;
        if (cntDown == 8'h00)
        begin
          nxt_down = 1'b0;
          periodEnd = 1'b1;
        end
      end
    end
    if (cntWrite)
    begin
      nxt_cnt = 8'h00;
      nxt_down = 1'b0;
    end
    // disabled channel passes buffers straight to the latches
    load = periodEnd || cntWrite || !enable;
    nxt_perAct = load ? nxt_perBuf : perAct_ff;
    nxt_dutyAct = load ? nxt_dutyBuf : dutyAct_ff;
    // level before the duty match follows polarity
    // center mode matches again on the way down: the polarity level lasts twice duty
    if (center && nxt_down)
      nxt_out = polarity ^ (nxt_cnt > nxt_dutyAct);
    else
      nxt_out = polarity ^ (nxt_cnt >= nxt_dutyAct);
  end

  // ==========================================================
  // registers
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt_ff <= `PSC_RST_BYTE;
      perBuf_ff <= `PSC_RST_BYTE;
      dutyBuf_ff <= `PSC_RST_BYTE;
      perAct_ff <= `PSC_RST_BYTE;
      dutyAct_ff <= `PSC_RST_BYTE;
      down_ff <= 1'b0;
      run_ff <= 1'b0;
      out_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      perBuf_ff <= nxt_perBuf;
      dutyBuf_ff <= nxt_dutyBuf;
      perAct_ff <= nxt_perAct;
      dutyAct_ff <= nxt_dutyAct;
      down_ff <= nxt_down;
      run_ff <= nxt_run;
      out_ff <= nxt_out;
    end
  end

  assign count = cnt_ff;
  assign periodBuf = perBuf_ff;
  assign dutyBuf = dutyBuf_ff;
  assign pwmOut = out_ff;

endmodule
`default_nettype wire

/* File: design/psc_pwm_top.v */
// two-channel 8-bit pwm with clock dividers and apb register slave
//
// Behaviour
// - scaled clock A is A over twice scale
// - scaled clock B is B over twice scale
// - scale zero means 256, divide by 512
// - scale write reloads its down-counter at once
// - each channel has 8-bit counter on its clock
// - counter read returns live count, no effect
// - left aligned counts zero to period minus one
// - center aligned counts up to period, down
// - counter write clears, up, loads, sets output
// - counter clears at end of each period
// - disabled channel counter holds its value
// - enabling resumes from current counter value
// - period writes buffered until period end events
// - duty writes buffered until period end events
// - disabled channel writes reach buffer and latch
// - period and duty reads return buffer value
// - output period is period or twice period
// - duty equal to counter toggles the output
// - polarity picks start level and duty meaning
// - high fraction is duty or period minus duty
// - prescaled clocks divide by powers of two
// - channel picks prescaled or scaled clock
// - enable takes effect on next source clock
// - alignment bit selects left or center mode
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "psc_defines.vh"

module psc_pwm_top (
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire pwm0,
  output wire pwm1
);

  // ==========================================================
  // apb slave state
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;
  reg hit;
  reg [7:0] rdByte;
  wire [8:0] regIdx;
  wire aligned;
  wire setup;
  wire wrDone;

  // ==========================================================
  // configuration registers
  reg [7:0] control_ff;
  reg [7:0] prescale_ff;
  reg [7:0] scaleA_ff;
  reg [7:0] scaleB_ff;
  reg [6:0] presc_ff;
  reg [6:0] nxt_presc;

  // ==========================================================
  // per-clock-path and per-channel wires
  wire [1:0] preTick;
  wire [1:0] scaleTick;
  wire [1:0] chanTick;
  wire [1:0] scaleWrite;
  wire [1:0] cntWrite;
  wire [1:0] perWrite;
  wire [1:0] dutyWrite;
  wire [1:0] pwmOut;
  wire [7:0] countCh0;
  wire [7:0] countCh1;
  wire [7:0] perCh0;
  wire [7:0] perCh1;
  wire [7:0] dutyCh0;
  wire [7:0] dutyCh1;
  wire [15:0] countAll;
  wire [15:0] perAll;
  wire [15:0] dutyAll;
  wire [15:0] scaleAll;
  wire [5:0] preSelAll;
  wire anyEnable;

  // ==========================================================
  // address decode
  assign regIdx = paddr[10:2];
  assign aligned = (paddr[1:0] == 2'h0) && !paddr[11];
  assign setup = psel && !penable;
  // write lands only at the edge where the access completes
  assign wrDone = psel && penable && pready_ff && pwrite && !pslverr_ff;

  always @*
  begin
    hit = aligned;
    rdByte = 8'h00;
    case (regIdx)
      `PSC_IDX_CONTROL:
        rdByte = control_ff;
      `PSC_IDX_PRESCALE:
        rdByte = prescale_ff;
      `PSC_IDX_SCALE_A:
        rdByte = scaleA_ff;
      `PSC_IDX_SCALE_B:
        rdByte = scaleB_ff;
      `PSC_IDX_COUNTER0:
        rdByte = countCh0;
      `PSC_IDX_COUNTER1:
        rdByte = countCh1;
      `PSC_IDX_PERIOD0:
        rdByte = perCh0;
      `PSC_IDX_PERIOD1:
        rdByte = perCh1;
      `PSC_IDX_DUTY0:
        rdByte = dutyCh0;
      `PSC_IDX_DUTY1:
        rdByte = dutyCh1;
      default:
        hit = 1'b0;
    endcase
    if (!aligned)
      rdByte = 8'h00;
    nxt_prdata = {24'h000000, rdByte};
    nxt_pslverr = !hit;
  end

  // ==========================================================
  // apb answer: read data captured in setup, no wait states
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setup;
      if (setup)
      begin
        prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end
      else if (!psel)
      begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================================
  // write strobes
  assign scaleWrite[0] = wrDone && (regIdx == `PSC_IDX_SCALE_A);
  assign scaleWrite[1] = wrDone && (regIdx == `PSC_IDX_SCALE_B);
  assign cntWrite[0] = wrDone && (regIdx == `PSC_IDX_COUNTER0);
  assign cntWrite[1] = wrDone && (regIdx == `PSC_IDX_COUNTER1);
  assign perWrite[0] = wrDone && (regIdx == `PSC_IDX_PERIOD0);
  assign perWrite[1] = wrDone && (regIdx == `PSC_IDX_PERIOD1);
  assign dutyWrite[0] = wrDone && (regIdx == `PSC_IDX_DUTY0);
  assign dutyWrite[1] = wrDone && (regIdx == `PSC_IDX_DUTY1);

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      control_ff <= `PSC_RST_BYTE;
      prescale_ff <= `PSC_RST_BYTE;
      scaleA_ff <= `PSC_RST_BYTE;
      scaleB_ff <= `PSC_RST_BYTE;
    end
    else
    begin
      if (wrDone && (regIdx == `PSC_IDX_CONTROL))
        control_ff <= pwdata[7:0];
      if (wrDone && (regIdx == `PSC_IDX_PRESCALE))
        prescale_ff <= pwdata[7:0] & `PSC_PRE_MASK;
      if (scaleWrite[0])
        scaleA_ff <= pwdata[7:0];
      if (scaleWrite[1])
        scaleB_ff <= pwdata[7:0];
    end
  end

  // ==========================================================
  // prescaler: stops when both channels are off to save power
  assign anyEnable = |control_ff[`PSC_CTL_ENABLE_LSB+1:`PSC_CTL_ENABLE_LSB];

  always @*
  begin
    nxt_presc = presc_ff;
    if (anyEnable)
      nxt_presc = presc_ff + 7'h01;
  end

  always @(posedge clock)
  begin
    if (sys_rst)
      presc_ff <= `PSC_RST_PRESC;
    else
      presc_ff <= nxt_presc;
  end

  assign scaleAll = {scaleB_ff, scaleA_ff};
  assign preSelAll = {prescale_ff[`PSC_PRE_B_LSB+2:`PSC_PRE_B_LSB],
    prescale_ff[`PSC_PRE_A_LSB+2:`PSC_PRE_A_LSB]};

  // ==========================================================
  // per path clock A/B dividers and per channel timers
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : gPath
      reg [7:0] scaleCnt_ff;
      reg half_ff;
      reg [7:0] nxt_scaleCnt;
      reg nxt_half;
      wire [2:0] preSel;
      wire [6:0] preMask;
      wire scalePulse;

      assign preSel = preSelAll[3*i+2:3*i];
      // divide by 2^sel: tick when the low sel bits are all ones
      assign preMask = ~(7'h7F << preSel);
      assign preTick[i] = anyEnable && ((presc_ff & preMask) == preMask);
      assign scalePulse = preTick[i] && (scaleCnt_ff == `PSC_SCALE_END);

      always @*
      begin
        nxt_scaleCnt = scaleCnt_ff;
        nxt_half = half_ff;
        if (preTick[i])
        begin
          // zero reloads as zero, then wraps: 256 ticks
          if (scaleCnt_ff == `PSC_SCALE_END)
          begin
            nxt_scaleCnt = scaleAll[8*i+7:8*i];
            nxt_half = !half_ff;
          end
          else
            nxt_scaleCnt = scaleCnt_ff - 8'h01;
        end
        if (scaleWrite[i])
          nxt_scaleCnt = pwdata[7:0];
      end

      always @(posedge clock)
      begin
        if (sys_rst)
        begin
          scaleCnt_ff <= `PSC_RST_BYTE;
          half_ff <= 1'b0;
        end
        else
        begin
          scaleCnt_ff <= nxt_scaleCnt;
          half_ff <= nxt_half;
        end
      end

      // the divide by two: one tick every second pulse
      assign scaleTick[i] = scalePulse && half_ff;
      assign chanTick[i] = control_ff[`PSC_CTL_CLKCHOICE_LSB+i] ?
        scaleTick[i] : preTick[i];

      psc_channel uChan (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(chanTick[i]),
        .enable(control_ff[`PSC_CTL_ENABLE_LSB+i]),
        .polarity(control_ff[`PSC_CTL_POLARITY_LSB+i]),
        .center(control_ff[`PSC_CTL_CENTER_LSB+i]),
        .cntWrite(cntWrite[i]),
        .perWrite(perWrite[i]),
        .dutyWrite(dutyWrite[i]),
        .wdata(pwdata[7:0]),
        .count(countAll[8*i+7:8*i]),
        .periodBuf(perAll[8*i+7:8*i]),
        .dutyBuf(dutyAll[8*i+7:8*i]),
        .pwmOut(pwmOut[i])
      );
    end
  endgenerate

  assign countCh0 = countAll[7:0];
  assign countCh1 = countAll[15:8];
  assign perCh0 = perAll[7:0];
  assign perCh1 = perAll[15:8];
  assign dutyCh0 = dutyAll[7:0];
  assign dutyCh1 = dutyAll[15:8];

  // outputs come straight from each channel's output flop
  assign pwm0 = pwmOut[0];
  assign pwm1 = pwmOut[1];

endmodule
`default_nettype wire

/* File: verif/psc_load_model.sv */
// load model on a pwm pin: measures period and high time in clocks
`timescale 1ns/10ps
`default_nettype none
// =====
// pin load
module psc_load_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pin,
  output int perLen,
  output int highLen
);
  int cnt;
  int hc;
  logic last;
  // a load only listens, so the pin has no far-side driver to model
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt <= 0;
      hc <= 0;
      last <= 1'b0;
      perLen <= 0;
      highLen <= 0;
    end
    else
    begin
      last <= pin;
      if (pin && !last)
      begin
        perLen <= cnt;
        highLen <= hc;
        cnt <= 1;
        hc <= 1;
      end
      else
      begin
        cnt <= cnt + 1;
        hc <= hc + int'(pin);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/psc_pwm_properties.sv */
// apb and reset checks at the pwm block ports
`timescale 1ns/10ps
`default_nettype none
// =====
// checker
module psc_pwm_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm0,
  input wire logic pwm1
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_mapped;
    paddr[1:0] == 2'h0 && !paddr[11] && paddr[10:2] >= 9'h060
      && paddr[10:2] <= 9'h069;
  endsequence
  property p_rdy;
    s_setup |=> pready;
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  property p_acc;
    pready |-> psel && penable;
  endproperty
  property p_ok;
    s_setup ##0 s_mapped |=> !pslverr;
  endproperty
  property p_unm;
    s_setup ##0 paddr[11] |=> pslverr && prdata == 32'h00000000;
  endproperty
  property p_una;
    s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr;
  endproperty
  property p_hi;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |=> !pwm0 && !pwm1 && !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready too long");
  a_acc: assert property (p_acc) else $error("ready outside access");
  a_ok: assert property (p_ok) else $error("error on mapped");
  a_unm: assert property (p_unm) else $error("unmapped accepted");
  a_una: assert property (p_una) else $error("unaligned accepted");
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind psc_pwm_top psc_pwm_properties chk_u (.clock(clock),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm0(pwm0), .pwm1(pwm1));
`default_nettype wire

/* File: verif/psc_pwm_top_tb.sv */
// self-checking bench for the two-channel pwm block
`timescale 1ns/10ps
`default_nettype none
`include "psc_defines.vh"
// =====
// bench
module psc_pwm_top_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic pwm0;
  wire logic pwm1;
  int p0, h0, p1, h1;
  int badCount = 0;
  int compares = 0;
  logic [7:0] rd;
  logic er;
  logic [7:0] keep;
  psc_pwm_top dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm0(pwm0),
    .pwm1(pwm1));
  psc_load_model ld0_u (.clock(clock), .sys_rst(sys_rst), .pin(pwm0),
    .perLen(p0), .highLen(h0));
  psc_load_model ld1_u (.clock(clock), .sys_rst(sys_rst), .pin(pwm1),
    .perLen(p1), .highLen(h1));
  initial
  begin
    forever #20 clock = ~clock;
  end
  task end_sim;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      badCount++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // ready is taken at the rising edge, before that edge's updates land
  task xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clock);
    end
    if (n >= 20)
      badCount++;
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [8:0] i, input logic [7:0] d);
    xfer({1'b0, i, 2'h0}, 1'b1, d);
  endtask
  task rdr(input logic [8:0] i);
    xfer({1'b0, i, 2'h0}, 1'b0, 8'h00);
  endtask
  task tReset;
    for (int i = `PSC_IDX_SCALE_A; i <= `PSC_IDX_DUTY1; i++)
    begin
      rdr(i[8:0]);
      chk("reset value", rd, 8'h00);
    end
  endtask
  task tErr;
    xfer(12'h800, 1'b0, 8'h00);
    chk("unmapped err", er, 1'b1);
    xfer({1'b0, `PSC_IDX_PERIOD0, 2'h1}, 1'b1, 8'h55);
    chk("unaligned err", er, 1'b1);
    rdr(`PSC_IDX_PERIOD0);
    chk("dropped write", rd, 8'h00);
  endtask
  task tBuf;
    wr(`PSC_IDX_PERIOD1, 8'h5A);
    wr(`PSC_IDX_DUTY1, 8'hA5);
    rdr(`PSC_IDX_PERIOD1);
    chk("period buf", rd, 8'h5A);
    rdr(`PSC_IDX_DUTY1);
    chk("duty buf", rd, 8'hA5);
  endtask
  // counter cleared only while disabled, an enabled write may glitch
  task runCase(input int ch, input logic [7:0] ctl, pre, scl, per, dty,
    input int eP, eH);
    wr(`PSC_IDX_CONTROL, 8'h00);
    wr(`PSC_IDX_PRESCALE, pre);
    wr(`PSC_IDX_SCALE_A, scl);
    wr(`PSC_IDX_SCALE_B, scl);
    wr(`PSC_IDX_PERIOD0 + ch, per);
    wr(`PSC_IDX_DUTY0 + ch, dty);
    wr(`PSC_IDX_COUNTER0 + ch, 8'h33);
    wr(`PSC_IDX_CONTROL, ctl);
    repeat (3 * eP + 20) @(posedge clock);
    chk("period", (ch == 1) ? p1 : p0, eP);
    if (eH != 0)
      chk("high time", (ch == 1) ? h1 : h0, eH);
  endtask
  task tDbl;
    runCase(0, 8'h05, 8'h00, 8'h01, 8'h04, 8'h01, 4, 1);
    wr(`PSC_IDX_PERIOD0, 8'h06);
    rdr(`PSC_IDX_PERIOD0);
    chk("period read", rd, 8'h06);
    chk("old period", p0, 4);
    repeat (40) @(posedge clock);
    chk("new period", p0, 6);
  endtask
  task tCnt;
    wr(`PSC_IDX_CONTROL, 8'h00);
    wr(`PSC_IDX_PRESCALE, 8'h00);
    wr(`PSC_IDX_PERIOD0, 8'hC8);
    wr(`PSC_IDX_COUNTER0, 8'h00);
    wr(`PSC_IDX_CONTROL, 8'h01);
    repeat (10) @(posedge clock);
    wr(`PSC_IDX_CONTROL, 8'h00);
    rdr(`PSC_IDX_COUNTER0);
    keep = rd;
    repeat (10) @(posedge clock);
    rdr(`PSC_IDX_COUNTER0);
    chk("held count", rd, keep);
    chk("count moved", keep > 8'h08, 1'b1);
    wr(`PSC_IDX_CONTROL, 8'h01);
    repeat (5) @(posedge clock);
    rdr(`PSC_IDX_COUNTER0);
    // a cleared counter would read about five here, below the held value
    chk("resumed count", rd > keep, 1'b1);
    wr(`PSC_IDX_CONTROL, 8'h00);
    wr(`PSC_IDX_COUNTER0, 8'hFF);
    rdr(`PSC_IDX_COUNTER0);
    chk("cleared count", rd, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    tReset();
    tErr();
    tBuf();
    tDbl();
    tCnt();
    runCase(0, 8'h01, 8'h00, 8'h01, 8'h05, 8'h02, 5, 3);
    runCase(0, 8'h41, 8'h00, 8'h01, 8'h03, 8'h01, 6, 4);
    runCase(0, 8'h15, 8'h01, 8'h03, 8'h02, 8'h01, 24, 12);
    runCase(0, 8'h15, 8'h00, 8'h00, 8'h02, 8'h01, 1024, 512);
    runCase(1, 8'h2A, 8'h20, 8'h01, 8'h03, 8'h02, 24, 16);
    end_sim();
  end
  // whole run is about 4k clocks, so this bound only trips on a hang
  initial
  begin
    #1000000;
    badCount++;
    end_sim();
  end
endmodule
`default_nettype wire
